// File: hw/bmr_bank.sv
// register bank: supervisor-fed temperatures, controls, counters and link watchdog
// Functional notes
// - missing alternation flags link lost
// - link lost forces inputs to sensor-open
// - after power-up inputs open until heartbeat plus value
// - out-of-range input write stores not-reliable
// - temperatures are Celsius times ten
// - reserved fault codes for temperature faults
// - current loop is milliamps times ten
// - setpoint reads out-of-high-range when mode inactive
// - firing rate reported zero to two hundred
// - 32-bit counters: high word then low word
// - enable and demand registers carry one flag in bit zero, upper fifteen bits read zero
// - enable zero disables service, one permits
// - demand zero removes demand, one reapplies
// - external values used only if source selected
`timescale 1ns/1ns
module bmr_bank #(
  parameter int TIMEOUT_CYCLES = bmr_pkg::TIMEOUT_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  input  wire logic [15:0]      addr_i,
  input  wire logic [15:0]      wdata_i,
  input  wire bmr_pkg::bmr_src_t src_sel_i,
  input  wire logic             cycle_inc_i,
  input  wire logic             hour_inc_i,
  input  wire logic [15:0]      fire_rate_i,
  input  wire logic             sh_active_i,
  input  wire logic             hw_active_i,
  output logic [15:0]           rdata_o,
  output logic                  link_lost_o,
  output logic                  sh_enable_o,
  output logic                  sh_demand_o,
  output logic                  hw_enable_o,
  output logic                  hw_demand_o,
  output logic [15:0]           sh_setpoint_o,
  output logic [15:0]           hw_setpoint_o,
  output logic [15:0]           tank_setpoint_o,
  output logic [15:0]           header_temp_o,
  output logic [15:0]           outdoor_temp_o,
  output logic [15:0]           loop_in_o,
  output logic [15:0]           hw_temp_o,
  output logic [15:0]           fire_rate_o
);
  import bmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic temp_ok(input logic [15:0] v);
    return ($signed(v) >= TEMP_MIN) && ($signed(v) <= TEMP_MAX);
  endfunction

  logic [31:0] cycle_cnt;
  logic [31:0] hour_cnt;
  logic [15:0] heartbeat;
  logic [15:0] sh_setpt;
  logic [15:0] hw_setpt;
  logic [15:0] tank_setpt;
  logic        sh_en;
  logic        sh_dem;
  logic        hw_en;
  logic        hw_dem;
  logic [15:0] ext_val [4];
  logic [3:0]  ext_seen;
  logic        hb_ok;
  logic [31:0] hb_timer;

  wire         wr_ce     = ce_i & wr_i;
  wire         hb_opp    = wr_ce && addr_i == REG_HEARTBEAT &&
                           ((wdata_i == HB_CODE_A && heartbeat == HB_CODE_B) ||
                            (wdata_i == HB_CODE_B && heartbeat == HB_CODE_A));
  wire         hb_expire = hb_ok && hb_timer >= 32'(TIMEOUT_CYCLES - 1);
  // a toggle in the expiry cycle keeps the link and its inputs
  wire         hb_drop   = hb_expire && !hb_opp;
  wire         loop_ok   = wdata_i >= LOOP_MIN && wdata_i <= LOOP_MAX;

  wire  [3:0]  ext_hit;
  assign ext_hit[IDX_HDR]  = wr_ce && addr_i == REG_HDR_TEMP;
  assign ext_hit[IDX_OUT]  = wr_ce && addr_i == REG_OUT_TEMP;
  assign ext_hit[IDX_LOOP] = wr_ce && addr_i == REG_LOOP_IN;
  assign ext_hit[IDX_HW]   = wr_ce && addr_i == REG_HW_TEMP;

  wire  [15:0] ext_store = ext_hit[IDX_LOOP] ? (loop_ok ? wdata_i : CODE_UNRELIABLE) :
                           (temp_ok(wdata_i) ? wdata_i : CODE_UNRELIABLE);

  ////////////////////////////////////////////////////////////////////////////
  // heartbeat watchdog; first opposite pair establishes the link
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      heartbeat <= 16'h0000;
      hb_ok     <= 1'b0;
      hb_timer  <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_ce && addr_i == REG_HEARTBEAT) heartbeat <= wdata_i;
      if (hb_opp) begin
        hb_ok    <= 1'b1;
        hb_timer <= 32'h0000_0000;
      end else if (hb_expire) begin
        hb_ok    <= 1'b0;
      end else if (hb_ok) begin
        hb_timer <= hb_timer + 32'h0000_0001;
      end
    end
  end

  // external inputs: open until link plus value, forced open on loss
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++) ext_val[i] <= CODE_OPEN;
      ext_seen <= 4'h0;
    end else if (ce_i) begin
      for (int i = 0; i < 4; i++) begin
        if (hb_drop) begin
          ext_val[i]  <= CODE_OPEN;
          ext_seen[i] <= 1'b0;
        end else if (ext_hit[i]) begin
          ext_seen[i] <= 1'b1;
          ext_val[i]  <= ext_store;
        end
      end
    end
  end

  // controls and setpoints
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_en      <= 1'b0;
      hw_en      <= 1'b0;
      sh_dem     <= 1'b0;
      hw_dem     <= 1'b0;
      sh_setpt   <= 16'h0000;
      hw_setpt   <= 16'h0000;
      tank_setpt <= 16'h0000;
    end else if (wr_ce) begin
      case (addr_i)
        REG_SH_ENABLE:  sh_en      <= wdata_i == ONE_WORD;
        REG_HW_ENABLE:  hw_en      <= wdata_i == ONE_WORD;
        REG_SH_DEMAND:  sh_dem     <= wdata_i == ONE_WORD;
        REG_HW_DEMAND:  hw_dem     <= wdata_i == ONE_WORD;
        REG_SH_SETPT:   sh_setpt   <= wdata_i;
        REG_HW_SETPT:   hw_setpt   <= wdata_i;
        REG_TANK_SETPT: tank_setpt <= wdata_i;
        default: ;
      endcase
    end
  end

  // counters saturate instead of wrapping to zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cycle_cnt <= 32'h0000_0000;
      hour_cnt  <= 32'h0000_0000;
    end else if (ce_i) begin
      if (cycle_inc_i && ~&cycle_cnt) cycle_cnt <= cycle_cnt + 32'h0000_0001;
      if (hour_inc_i && ~&hour_cnt)   hour_cnt  <= hour_cnt + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire [15:0] sh_setpt_rd = sh_active_i ? sh_setpt : CODE_HIGH;
  wire [15:0] hw_setpt_rd = hw_active_i ? hw_setpt : CODE_HIGH;
  wire [15:0] tk_setpt_rd = hw_active_i ? tank_setpt : CODE_HIGH;
  wire [15:0] fire_clip   = fire_rate_i > FIRE_MAX ? FIRE_MAX : fire_rate_i;
  wire [15:0] hours_hi    = hour_cnt[31:16];
  wire [15:0] ext_rd [4];
  for (genvar g = 0; g < 4; g++) begin : g_ext
    assign ext_rd[g] = (hb_ok && ext_seen[g]) ? ext_val[g] : CODE_OPEN;
  end

  logic [15:0] next_rdata;
  always_comb begin
    case (addr_i)
      REG_CYCLE_HI:   next_rdata = cycle_cnt[31:16];
      REG_CYCLE_LO:   next_rdata = cycle_cnt[15:0];
      REG_HOURS_HI:   next_rdata = hour_cnt[31:16];
      REG_HOURS_LO:   next_rdata = hour_cnt[15:0];
      REG_HEARTBEAT:  next_rdata = heartbeat;
      REG_SH_ENABLE:  next_rdata = {15'h0000, sh_en};
      REG_SH_SETPT:   next_rdata = sh_setpt_rd;
      REG_SH_DEMAND:  next_rdata = {15'h0000, sh_dem};
      REG_HDR_TEMP:   next_rdata = ext_rd[IDX_HDR];
      REG_OUT_TEMP:   next_rdata = ext_rd[IDX_OUT];
      REG_LOOP_IN:    next_rdata = ext_rd[IDX_LOOP];
      REG_HW_ENABLE:  next_rdata = {15'h0000, hw_en};
      REG_HW_SETPT:   next_rdata = hw_setpt_rd;
      REG_TANK_SETPT: next_rdata = tk_setpt_rd;
      REG_HW_DEMAND:  next_rdata = {15'h0000, hw_dem};
      REG_HW_TEMP:    next_rdata = ext_rd[IDX_HW];
      default:        next_rdata = 16'h0000;
    endcase
  end

  // outputs registered; external values gated by configured source
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o         <= 16'h0000;
      link_lost_o     <= 1'b1;
      sh_enable_o     <= 1'b0;
      hw_enable_o     <= 1'b0;
      sh_demand_o     <= 1'b0;
      hw_demand_o     <= 1'b0;
      sh_setpoint_o   <= CODE_HIGH;
      hw_setpoint_o   <= CODE_HIGH;
      tank_setpoint_o <= CODE_HIGH;
      header_temp_o   <= CODE_OPEN;
      outdoor_temp_o  <= CODE_OPEN;
      loop_in_o       <= CODE_OPEN;
      hw_temp_o       <= CODE_OPEN;
      fire_rate_o     <= 16'h0000;
    end else if (ce_i) begin
      if (rd_i) rdata_o <= next_rdata;
      link_lost_o     <= ~hb_ok;
      sh_enable_o     <= sh_en;
      hw_enable_o     <= hw_en;
      sh_demand_o     <= sh_en & sh_dem & src_sel_i.demand;
      hw_demand_o     <= hw_en & hw_dem & src_sel_i.demand;
      sh_setpoint_o   <= src_sel_i.setpoint ? sh_setpt : CODE_HIGH;
      hw_setpoint_o   <= src_sel_i.setpoint ? hw_setpt : CODE_HIGH;
      tank_setpoint_o <= src_sel_i.setpoint ? tank_setpt : CODE_HIGH;
      header_temp_o   <= src_sel_i.temperature ? ext_rd[IDX_HDR] : CODE_OPEN;
      outdoor_temp_o  <= src_sel_i.temperature ? ext_rd[IDX_OUT] : CODE_OPEN;
      loop_in_o       <= src_sel_i.temperature ? ext_rd[IDX_LOOP] : CODE_OPEN;
      hw_temp_o       <= src_sel_i.temperature ? ext_rd[IDX_HW] : CODE_OPEN;
      fire_rate_o     <= fire_clip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence hb_toggle_s;
    hb_opp;
  endsequence
  sequence hb_alive_s;
    ##1 (hb_ok && hb_timer == 32'h0000_0000);
  endsequence

  // checks guard the watchdog, the input codes and the read path
  hb_restart_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i and hb_toggle_s) |-> hb_alive_s)
    else $error("heartbeat toggle did not restart timer");
  hb_loss_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && hb_expire && !hb_opp |=> !hb_ok ##1 (link_lost_o || !$past(ce_i)))
    else $error("timeout did not drop link");
  loss_open_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && hb_expire && !hb_opp |=> ext_val[IDX_HDR] == CODE_OPEN)
    else $error("link loss did not force sensor open");
  open_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !hb_ok |=> outdoor_temp_o == CODE_OPEN && hw_temp_o == CODE_OPEN)
    else $error("input visible without link");
  bad_temp_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ext_hit[IDX_HDR] && !temp_ok(wdata_i) && !hb_expire |=> ext_val[IDX_HDR] == CODE_UNRELIABLE)
    else $error("bad temperature stored");
  bad_loop_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ext_hit[IDX_LOOP] && !loop_ok && !hb_expire |=> ext_val[IDX_LOOP] == CODE_UNRELIABLE)
    else $error("bad loop value stored");
  setpt_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !sh_active_i && addr_i == REG_SH_SETPT |-> next_rdata == CODE_HIGH)
    else $error("inactive setpoint not flagged");
  fire_cap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fire_rate_o <= FIRE_MAX)
    else $error("firing rate above range");
  ctr_ro_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_ce && (addr_i == REG_CYCLE_HI || addr_i == REG_CYCLE_LO) && !cycle_inc_i
      |=> $stable(cycle_cnt))
    else $error("counter changed by write");
  demand_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !sh_dem |=> !sh_demand_o)
    else $error("demand output without demand");
  enable_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !hw_en |=> !hw_demand_o)
    else $error("service disabled but demand out");
  cnt_split_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && rd_i && addr_i == REG_HOURS_HI |=> rdata_o == $past(hours_hi))
    else $error("counter high half misread");
  loop_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ext_hit[IDX_LOOP] && loop_ok && !hb_expire |=> ext_val[IDX_LOOP] == $past(wdata_i))
    else $error("valid loop value not stored");
  temp_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ext_hit[IDX_OUT] && temp_ok(wdata_i) && !hb_expire |=> ext_val[IDX_OUT] == $past(wdata_i))
    else $error("valid temperature not stored");
  fault_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    temp_ok(ext_val[IDX_HDR]) || ext_val[IDX_HDR] == CODE_OPEN ||
      ext_val[IDX_HDR] == CODE_UNRELIABLE)
    else $error("header value neither valid nor fault code");
  src_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !src_sel_i.temperature |=> header_temp_o == CODE_OPEN && loop_in_o == CODE_OPEN)
    else $error("input used without supervisor source");
  flag_bits_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && rd_i && addr_i == REG_SH_ENABLE |=> rdata_o[15:1] == 15'h0000)
    else $error("unused flag bits set");
  timer_run_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && hb_ok && !hb_opp && !hb_expire |=> hb_timer == $past(hb_timer) + 32'h0000_0001)
    else $error("heartbeat timer restarted without toggle");
  ce_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !ce_i |=> $stable(cycle_cnt) && $stable(hb_timer) && $stable(heartbeat))
    else $error("state moved with clock enable low");
endmodule

// File: hw/bmr_pkg.sv
// package: register map, fault codes and timing for the supervisor register bank
package bmr_pkg;
  localparam logic [15:0] REG_CYCLE_HI   = 16'h0097;
  localparam logic [15:0] REG_CYCLE_LO   = 16'h0098;
  localparam logic [15:0] REG_HOURS_HI   = 16'h0099;
  localparam logic [15:0] REG_HOURS_LO   = 16'h009A;
  localparam logic [15:0] REG_HEARTBEAT  = 16'h00AA;
  localparam logic [15:0] REG_SH_ENABLE  = 16'h00AB;
  localparam logic [15:0] REG_SH_SETPT   = 16'h00AC;
  localparam logic [15:0] REG_SH_DEMAND  = 16'h00AD;
  localparam logic [15:0] REG_HDR_TEMP   = 16'h00AE;
  localparam logic [15:0] REG_OUT_TEMP   = 16'h00AF;
  localparam logic [15:0] REG_LOOP_IN    = 16'h00B0;
  localparam logic [15:0] REG_HW_ENABLE  = 16'h00BF;
  localparam logic [15:0] REG_HW_SETPT   = 16'h00C0;
  localparam logic [15:0] REG_TANK_SETPT = 16'h00C1;
  localparam logic [15:0] REG_HW_DEMAND  = 16'h00C2;
  localparam logic [15:0] REG_HW_TEMP    = 16'h00C3;
  localparam logic [15:0] HB_CODE_A      = 16'hABCD;
  localparam logic [15:0] HB_CODE_B      = 16'hDCBA;
  localparam logic [15:0] CODE_SHORT     = 16'h8000;
  localparam logic [15:0] CODE_OPEN      = 16'h8100;
  localparam logic [15:0] CODE_HIGH      = 16'h8300;
  localparam logic [15:0] CODE_LOW       = 16'h8400;
  localparam logic [15:0] CODE_UNRELIABLE = 16'h8500;
  localparam logic signed [15:0] TEMP_MIN = 16'shFE70;
  localparam logic signed [15:0] TEMP_MAX = 16'sh0514;
  localparam logic [15:0] LOOP_MIN       = 16'h0028;
  localparam logic [15:0] LOOP_MAX       = 16'h00C8;
  localparam logic [15:0] FIRE_MAX       = 16'h00C8;
  localparam logic [15:0] ONE_WORD       = 16'h0001;
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          TIMEOUT_MS     = 10_000;
  localparam int          TIMEOUT_CYC    = (CLK_HZ / 1000) * TIMEOUT_MS;
  // which value each external input follows
  typedef struct packed {
    logic setpoint;
    logic demand;
    logic temperature;
  } bmr_src_t;
  typedef enum logic [1:0] { IDX_HDR, IDX_OUT, IDX_LOOP, IDX_HW } bmr_idx_t;
endpackage

// File: tb/bmr_supervisor.sv
// supervisor model: register master that writes and reads the bank
`timescale 1ns/1ns
module bmr_supervisor
  import bmr_pkg::*;
(
  input  wire logic        clk_i,
  output logic             ce_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic [15:0]      addr_o,
  output logic [15:0]      wdata_o
);
  logic hb_odd = 1'b0;
  initial begin
    ce_o = 1'b1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one strobe cycle, then released lines show the inverse so stale data is not read
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(negedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // each call sends the opposite word of the previous one
  task automatic beat();
    hb_odd = !hb_odd;
    xfer(1'b1, REG_HEARTBEAT, hb_odd ? HB_CODE_A : HB_CODE_B);
  endtask
  task automatic set_ce(input logic en);
    @(negedge clk_i);
    ce_o <= en;
  endtask
endmodule

// File: tb/bmr_bank_bench.sv
// testbench: register bank driven by the supervisor model, read data checked through a queue
`timescale 1ns/1ns
module bmr_bank_bench;
  import bmr_pkg::*;
  localparam int TO = 200;
  localparam logic [15:0] TA [9] = '{REG_HDR_TEMP, REG_HDR_TEMP, REG_HDR_TEMP, REG_OUT_TEMP,
    REG_OUT_TEMP, REG_LOOP_IN, REG_LOOP_IN, REG_LOOP_IN, REG_LOOP_IN};
  localparam logic [15:0] TV [9] = '{16'h02AB, 16'hFE6F, 16'hFE70, 16'h0514, 16'h0515,
    16'h0028, 16'h0027, 16'h00C8, 16'h00C9};
  localparam logic [15:0] TE [9] = '{16'h02AB, CODE_UNRELIABLE, 16'hFE70, 16'h0514,
    CODE_UNRELIABLE, 16'h0028, CODE_UNRELIABLE, 16'h00C8, CODE_UNRELIABLE};
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        ce, wr, rd, lost, sh_en, sh_dm, hw_en, hw_dm;
  logic [15:0] addr, wdata, rdata, sh_sp, hw_sp, tk_sp, hdr_t, out_t, loop_t, hw_t, fire_o;
  bmr_src_t    src_sel = '0;
  logic        cyc_inc = 1'b0, hr_inc = 1'b0, sh_act = 1'b0, hw_act = 1'b0;
  logic [15:0] fire = 16'h0000;
  logic [15:0] exp_q [$];
  logic [1:0]  rd_p = 2'b00;
  int          num_errors = 0;
  int          checks_done = 0;
  always #25 clk_i = !clk_i;
  bmr_supervisor sup (.clk_i(clk_i), .ce_o(ce), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata));
  bmr_bank #(.TIMEOUT_CYCLES(TO)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .src_sel_i(src_sel),
    .cycle_inc_i(cyc_inc), .hour_inc_i(hr_inc), .fire_rate_i(fire), .sh_active_i(sh_act),
    .hw_active_i(hw_act), .rdata_o(rdata), .link_lost_o(lost), .sh_enable_o(sh_en),
    .sh_demand_o(sh_dm), .hw_enable_o(hw_en), .hw_demand_o(hw_dm), .sh_setpoint_o(sh_sp),
    .hw_setpoint_o(hw_sp), .tank_setpoint_o(tk_sp), .header_temp_o(hdr_t),
    .outdoor_temp_o(out_t), .loop_in_o(loop_t), .hw_temp_o(hw_t), .fire_rate_o(fire_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0) num_errors++;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wset(input logic [15:0] a, input logic [15:0] d);
    sup.xfer(1'b1, a, d);
    @(negedge clk_i);
  endtask
  task automatic rd_exp(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    sup.xfer(1'b0, a, 16'h0000);
    @(negedge clk_i);
  endtask
  // read data is registered on the request edge and checked at the falling edge after the next rising edge
  always @(posedge clk_i) rd_p <= {rd_p[0], ce & rd};
  always @(negedge clk_i) begin
    if (rd_p[1] && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    void'($urandom(48130));
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    chk({15'h0000, lost}, 16'h0001);
    chk(hdr_t, CODE_OPEN);
    chk(sh_sp, CODE_HIGH);
    $display("reset test done");
    src_sel = '1;
    sup.beat();
    sup.beat();
    repeat (2) @(negedge clk_i);
    chk({15'h0000, lost}, 16'h0000);
    chk(out_t, CODE_OPEN);
    for (int n = 0; n < 9; n++) begin
      wset(TA[n], TV[n]);
      rd_exp(TA[n], TE[n]);
    end
    v = 16'($urandom_range(1700)) - 16'h0190;
    wset(REG_HW_TEMP, v);
    chk(hw_t, v);
    chk(loop_t, CODE_UNRELIABLE);
    $display("input range test done");
    sup.beat();
    wset(REG_SH_ENABLE, 16'h0001);
    wset(REG_SH_DEMAND, 16'h0001);
    wset(REG_HW_ENABLE, 16'h0001);
    wset(REG_HW_DEMAND, 16'h0001);
    chk({12'h000, sh_en, sh_dm, hw_en, hw_dm}, 16'h000F);
    wset(REG_SH_DEMAND, 16'h0000);
    wset(REG_HW_ENABLE, 16'h0000);
    chk({12'h000, sh_en, sh_dm, hw_en, hw_dm}, 16'h0008);
    src_sel.demand = 1'b0;
    wset(REG_SH_DEMAND, 16'h0001);
    chk({15'h0000, sh_dm}, 16'h0000);
    $display("enable and demand test done");
    sup.beat();
    sh_act = 1'b1;
    hw_act = 1'b1;
    wset(REG_SH_SETPT, 16'h031A);
    wset(REG_TANK_SETPT, 16'h0258);
    wset(REG_HW_SETPT, 16'h0294);
    chk(sh_sp, 16'h031A);
    chk(tk_sp, 16'h0258);
    chk(hw_sp, 16'h0294);
    rd_exp(REG_SH_SETPT, 16'h031A);
    sh_act = 1'b0;
    src_sel.setpoint = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(sh_sp, CODE_HIGH);
    chk(tk_sp, CODE_HIGH);
    chk(hw_sp, CODE_HIGH);
    rd_exp(REG_SH_SETPT, CODE_HIGH);
    rd_exp(REG_TANK_SETPT, 16'h0258);
    fire = 16'($urandom_range(200));
    repeat (2) @(negedge clk_i);
    chk(fire_o, fire);
    fire = 16'h00FA;
    repeat (2) @(negedge clk_i);
    chk(fire_o, FIRE_MAX);
    $display("setpoint and firing test done");
    repeat (4) begin
      sup.beat();
      repeat (150) @(negedge clk_i);
    end
    chk({15'h0000, lost}, 16'h0000);
    chk(hdr_t, 16'hFE70);
    src_sel.temperature = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(hdr_t, CODE_OPEN);
    src_sel.temperature = 1'b1;
    repeat (4) begin
      sup.xfer(1'b1, REG_HEARTBEAT, sup.hb_odd ? HB_CODE_A : HB_CODE_B);
      repeat (100) @(negedge clk_i);
    end
    chk({15'h0000, lost}, 16'h0001);
    chk(hdr_t, CODE_OPEN);
    chk(out_t, CODE_OPEN);
    sup.beat();
    sup.beat();
    repeat (2) @(negedge clk_i);
    chk(hdr_t, CODE_OPEN);
    $display("link loss test done");
    cyc_inc = 1'b1;
    repeat (3) @(negedge clk_i);
    cyc_inc = 1'b0;
    rd_exp(REG_CYCLE_HI, 16'h0000);
    rd_exp(REG_CYCLE_LO, 16'h0003);
    wset(REG_CYCLE_LO, 16'hFFFF);
    rd_exp(REG_CYCLE_LO, 16'h0003);
    rd_exp(16'h00B5, 16'h0000);
    sup.set_ce(1'b0);
    cyc_inc = 1'b1;
    wset(REG_SH_ENABLE, 16'h0000);
    cyc_inc = 1'b0;
    sup.set_ce(1'b1);
    rd_exp(REG_CYCLE_LO, 16'h0003);
    rd_exp(REG_SH_ENABLE, 16'h0001);
    hr_inc = 1'b1;
    repeat (65537) @(negedge clk_i);
    hr_inc = 1'b0;
    rd_exp(REG_HOURS_HI, 16'h0001);
    rd_exp(REG_HOURS_LO, 16'h0001);
    repeat (3) @(negedge clk_i);
    $display("counter test done");
    stop_test();
  end
endmodule
